// file: core/lacc_pkg.sv
// Behaviour
// RULE1 - bits 19..17 select the word: 101 load-adaptive word, 110 stall and scale word; reserved bits are written as zero.
// RULE2 - a lower threshold of zero turns load-adaptive scaling off entirely.
// RULE3 - with a nonzero lower threshold, a sample below lower threshold times 32 raises the scaling factor.
// RULE4 - increment size 00/01/10/11 adds 1/2/4/8 steps per below-threshold sample.
// RULE5 - upper threshold is (lower + offset + 1) times 32; enough samples at or above it lower the factor.
// RULE6 - decrement rate 00/01/10/11 needs 32/8/2/1 high samples per single decrement.
// RULE7 - minimum current select clear gives a floor of half the scale, set gives a quarter.
// RULE8 - the factor saturates between the floor and the full scale setting, never wrapping.
// RULE9 - filter enable clear passes every measurement, set updates it once per four full steps.
// RULE10 - the stall threshold in bits 14..8 is a seven-bit two's complement value, -64 to +63.
// RULE11 - the stall threshold offsets the measurement; a lower threshold flags a stall at less torque.
// RULE12 - the current scale field scales both coil references by (value + 1) / 32.
// RULE13 - the scale applies the same for serial-commanded and step/direction motion.
package lacc_pkg;
    localparam logic [2:0] LACC_SEL_LOAD = 3'h5;
    localparam logic [2:0] LACC_SEL_STALL = 3'h6;
    localparam int LACC_SEL_LSB = 17;
    localparam logic [19:0] LACC_LOAD_RESV = 20'h1_1090;
    localparam logic [19:0] LACC_STALL_RESV = 20'h0_80e0;
    localparam int LACC_LOW_LSB = 0;
    localparam int LACC_INC_LSB = 5;
    localparam int LACC_OFS_LSB = 8;
    localparam int LACC_DEC_LSB = 13;
    localparam int LACC_MIN_BIT = 15;
    localparam int LACC_FILT_BIT = 16;
    localparam int LACC_SGT_LSB = 8;
    localparam int LACC_CS_LSB = 0;
    localparam int LACC_THR_UNIT = 32;
    localparam int LACC_FILT_STEPS = 4;
    localparam logic [19:0] LACC_LOAD_RST = 20'h0_0000;
    localparam logic [19:0] LACC_STALL_RST = 20'h0_001f;
    // register port offsets
    localparam logic [3:0] LACC_ADR_LOAD = 4'h0;
    localparam logic [3:0] LACC_ADR_STALL = 4'h1;
    localparam logic [3:0] LACC_ADR_STAT = 4'h2;
    localparam logic [3:0] LACC_ADR_IRQ = 4'h3;
    localparam logic [3:0] LACC_ADR_MASK = 4'h4;
    localparam logic [3:0] LACC_ADR_MEAS = 4'h5;
    // irq bits: 0 stall, 1 factor at floor, 2 factor at full, 3 bad write
    localparam int LACC_IRQ_W = 4;
endpackage

// file: core/lacc_step_if.sv
`timescale 1ns/1ns
interface lacc_step_if;
    logic sample;
    logic [9:0] meas;
    logic [3:0] low;
    logic [3:0] ofs;
    logic [1:0] inc;
    logic [1:0] dec;
    logic min_sel;
    logic [4:0] cs;
    logic [4:0] factor;
    logic at_floor;
    logic at_full;
    modport ctrl (output sample, meas, low, ofs, inc, dec, min_sel, cs,
        input factor, at_floor, at_full);
    modport stepper (input sample, meas, low, ofs, inc, dec, min_sel, cs,
        output factor, at_floor, at_full);
endinterface

// file: core/lacc_stepper.sv
`timescale 1ns/1ns
module lacc_stepper
    import lacc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    lacc_step_if.stepper bus
);
    typedef struct packed {
        logic [4:0] factor;
        logic [5:0] cnt;
    } lacc_stp_t;
    lacc_stp_t st_r;
    lacc_stp_t st_nxt;

    function automatic logic [4:0] lacc_floor(input logic [4:0] cs,
        input logic sel);
        logic [5:0] full;
        logic [4:0] q;
        full = {1'b0, cs} + 6'h01;
        // floor as a factor code: fraction of (cs+1) minus one, min 0
        if (sel) begin
            q = {1'b0, full[5:2]};
        end else begin
            q = full[5:1];
        end
        // tiny scale settings would wrap below zero without the clamp
        lacc_floor = (q == 5'h00) ? 5'h00 : q - 5'h01;
    endfunction

    function automatic logic [5:0] lacc_need(input logic [1:0] d);
        case (d)
            2'h0: lacc_need = 6'h20; // RULE6
            2'h1: lacc_need = 6'h08;
            2'h2: lacc_need = 6'h02;
            default: lacc_need = 6'h01;
        endcase
    endfunction

    logic [4:0] flo;
    logic [9:0] lo_thr;
    logic [9:0] hi_thr;
    logic [5:0] sum;
    always_comb begin
        st_nxt = st_r;
        flo = lacc_floor(bus.cs, bus.min_sel); // RULE7
        lo_thr = 10'({bus.low, 5'h00}); // RULE3
        hi_thr = (10'(bus.low) + 10'(bus.ofs) + 10'h001)
            * 10'(LACC_THR_UNIT);
        sum = 6'(st_r.factor) + (6'h01 << bus.inc); // RULE4
        if (bus.low == 4'h0) begin
            st_nxt.factor = bus.cs; // RULE2
            st_nxt.cnt = 6'h00;
        end else if (bus.sample) begin
            if (bus.meas < lo_thr) begin
                st_nxt.cnt = 6'h00;
                st_nxt.factor = (sum > 6'(bus.cs)) ? bus.cs : sum[4:0]; // RULE8
            end else if (bus.meas >= hi_thr) begin
                if (st_r.cnt + 6'h01 >= lacc_need(bus.dec)) begin // RULE5
                    st_nxt.cnt = 6'h00;
                    if (st_r.factor > flo) begin
                        st_nxt.factor = st_r.factor - 5'h01; // RULE8
                    end
                end else begin
                    st_nxt.cnt = st_r.cnt + 6'h01;
                end
            end
        end
        if (st_nxt.factor > bus.cs) begin
            st_nxt.factor = bus.cs; // RULE8
        end
        if (st_nxt.factor < flo) begin
            st_nxt.factor = flo;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign bus.factor = st_r.factor;
    assign bus.at_floor = (bus.low != 4'h0) && (st_r.factor == flo);
    assign bus.at_full = (st_r.factor == bus.cs);

    property p_disabled_full;
        @(posedge i_clk) disable iff (!i_rst_n)
        (bus.low == 4'h0) ##1 (bus.low == 4'h0 && $stable(bus.cs))
        |-> st_r.factor == bus.cs;
    endproperty
    a_disabled_full: assert property (p_disabled_full) // RULE2
        else $error("factor not full while disabled");
    property p_never_above;
        @(posedge i_clk) disable iff (!i_rst_n)
        $stable(bus.cs) |-> st_r.factor <= bus.cs;
    endproperty
    a_never_above: assert property (p_never_above) // RULE8
        else $error("factor above scale");
    property p_low_raises;
        @(posedge i_clk) disable iff (!i_rst_n)
        (bus.sample && bus.low != 4'h0 && bus.meas < lo_thr
         && st_r.factor < bus.cs && $stable(bus.cs))
        |=> st_r.factor > $past(st_r.factor);
    endproperty
    a_low_raises: assert property (p_low_raises) // RULE3
        else $error("low sample did not raise factor");
    property p_single_dec;
        @(posedge i_clk) disable iff (!i_rst_n)
        (bus.low != 4'h0 && bus.meas >= hi_thr && bus.sample)
        |=> 6'(st_r.factor) + 6'h01 >= 6'($past(st_r.factor));
    endproperty
    a_single_dec: assert property (p_single_dec) // RULE6
        else $error("decrement larger than one");
    c_raise: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        bus.sample && bus.meas < lo_thr && bus.low != 4'h0);
    c_floor: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        bus.at_floor);
endmodule

// file: core/lacc_top.sv
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
module lacc_top
    import lacc_pkg::*;
#(
    parameter int MEAS_W = 10
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [3:0] i_addr,
    input wire logic [19:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_meas_valid,
    input wire logic [MEAS_W-1:0] i_meas,
    input wire logic i_fullstep,
    input wire logic [7:0] i_coil_a,
    input wire logic [7:0] i_coil_b,
    output logic [19:0] o_rdata,
    output logic [7:0] o_coil_a,
    output logic [7:0] o_coil_b,
    output logic [4:0] o_factor,
    output logic [MEAS_W-1:0] o_load_measurement,
    output logic o_stall_indicator_out,
    output logic o_irq
);
    typedef struct packed {
        logic [19:0] load_cfg;
        logic [19:0] stall_cfg;
        logic [MEAS_W-1:0] meas;
        logic [1:0] steps;
        logic smp;
        logic [LACC_IRQ_W-1:0] irq;
        logic [LACC_IRQ_W-1:0] mask;
        logic [19:0] rdata;
        logic [7:0] coil_a;
        logic [7:0] coil_b;
        logic [4:0] factor;
        logic stall;
        logic irq_out;
    } lacc_top_t;
    lacc_top_t s_r;
    lacc_top_t s_nxt;
    logic rst_n;
    logic [1:0] rst_sync_r;
    lacc_step_if sbus ();

    // reset release through two flops; only sync[1] is read
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    function automatic logic [7:0] lacc_scale(input logic [7:0] ref_v,
        input logic [4:0] f);
        logic [13:0] p;
        p = 14'(ref_v) * 14'({1'b0, f} + 6'h01);
        lacc_scale = p[12:5]; // RULE12
    endfunction

    logic wr_load;
    logic wr_stall;
    logic bad_wr;
    logic signed [MEAS_W+1:0] adj;
    logic signed [6:0] stall_threshold;
    logic [LACC_IRQ_W-1:0] ev;
    always_comb begin
        s_nxt = s_r;
        wr_load = i_wr && i_addr == LACC_ADR_LOAD
            && i_wdata[19:LACC_SEL_LSB] == LACC_SEL_LOAD; // RULE1
        wr_stall = i_wr && i_addr == LACC_ADR_STALL
            && i_wdata[19:LACC_SEL_LSB] == LACC_SEL_STALL; // RULE1
        bad_wr = i_wr && ((i_addr == LACC_ADR_LOAD && !wr_load)
            || (i_addr == LACC_ADR_STALL && !wr_stall));
        if (wr_load) begin
            s_nxt.load_cfg = i_wdata & ~LACC_LOAD_RESV; // RULE1
        end
        if (wr_stall) begin
            s_nxt.stall_cfg = i_wdata & ~LACC_STALL_RESV;
        end
        // filtered mode: hold samples until four full steps passed
        s_nxt.smp = 1'b0;
        if (i_fullstep) begin
            s_nxt.steps = s_r.steps + 2'h1;
        end
        if (i_meas_valid) begin
            if (!s_r.stall_cfg[LACC_FILT_BIT]) begin
                s_nxt.meas = i_meas; // RULE9
                s_nxt.smp = 1'b1;
            end else if (s_r.steps == 2'(LACC_FILT_STEPS - 1)
                && i_fullstep) begin
                s_nxt.meas = i_meas; // RULE9
                s_nxt.smp = 1'b1;
            end
        end
        // signed threshold shifts the zero point of the stall flag
        stall_threshold = s_r.stall_cfg[LACC_SGT_LSB+:7]; // RULE10
        adj = $signed({2'b00, s_r.meas}) + 12'(stall_threshold); // RULE11
        s_nxt.stall = adj <= 0; // RULE11
        s_nxt.factor = sbus.factor;
        // same scaling on both motion sources: refs already merged
        s_nxt.coil_a = lacc_scale(i_coil_a, sbus.factor); // RULE13
        s_nxt.coil_b = lacc_scale(i_coil_b, sbus.factor); // RULE13
        ev = {bad_wr, sbus.at_full, sbus.at_floor, s_nxt.stall && !s_r.stall};
        if (i_wr && i_addr == LACC_ADR_IRQ) begin
            s_nxt.irq = s_r.irq & ~i_wdata[LACC_IRQ_W-1:0];
        end
        s_nxt.irq = s_nxt.irq | ev; // set beats clear
        if (i_wr && i_addr == LACC_ADR_MASK) begin
            s_nxt.mask = i_wdata[LACC_IRQ_W-1:0];
        end
        s_nxt.irq_out = |(s_nxt.irq & s_nxt.mask);
        s_nxt.rdata = 20'h0_0000;
        if (i_rd) begin
            case (i_addr)
                LACC_ADR_STAT: s_nxt.rdata = 20'({s_r.stall, sbus.factor});
                LACC_ADR_IRQ: s_nxt.rdata = 20'(s_r.irq);
                LACC_ADR_MASK: s_nxt.rdata = 20'(s_r.mask);
                LACC_ADR_MEAS: s_nxt.rdata = 20'(s_r.meas);
                default: s_nxt.rdata = 20'h0_0000;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r.load_cfg <= LACC_LOAD_RST;
            s_r.stall_cfg <= LACC_STALL_RST;
            s_r.meas <= '0;
            s_r.steps <= 2'h0;
            s_r.smp <= 1'b0;
            s_r.irq <= '0;
            s_r.mask <= '0;
            s_r.rdata <= 20'h0_0000;
            s_r.coil_a <= 8'h00;
            s_r.coil_b <= 8'h00;
            s_r.factor <= 5'h00;
            s_r.stall <= 1'b0;
            s_r.irq_out <= 1'b0;
        end else begin
            s_r.load_cfg <= s_nxt.load_cfg;
            s_r.stall_cfg <= s_nxt.stall_cfg;
            s_r.meas <= s_nxt.meas;
            s_r.steps <= s_nxt.steps;
            s_r.smp <= s_nxt.smp;
            s_r.irq <= s_nxt.irq;
            s_r.mask <= s_nxt.mask;
            s_r.rdata <= s_nxt.rdata;
            s_r.coil_a <= s_nxt.coil_a;
            s_r.coil_b <= s_nxt.coil_b;
            s_r.factor <= s_nxt.factor;
            s_r.stall <= s_nxt.stall;
            s_r.irq_out <= s_nxt.irq_out;
        end
    end

    assign sbus.sample = s_r.smp;
    assign sbus.meas = 10'(s_r.meas);
    assign sbus.low = s_r.load_cfg[LACC_LOW_LSB+:4];
    assign sbus.ofs = s_r.load_cfg[LACC_OFS_LSB+:4];
    assign sbus.inc = s_r.load_cfg[LACC_INC_LSB+:2];
    assign sbus.dec = s_r.load_cfg[LACC_DEC_LSB+:2];
    assign sbus.min_sel = s_r.load_cfg[LACC_MIN_BIT];
    assign sbus.cs = s_r.stall_cfg[LACC_CS_LSB+:5];

    lacc_stepper u_step (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .bus(sbus.stepper)
    );

    assign o_rdata = s_r.rdata;
    assign o_coil_a = s_r.coil_a;
    assign o_coil_b = s_r.coil_b;
    assign o_factor = s_r.factor;
    assign o_load_measurement = s_r.meas;
    assign o_stall_indicator_out = s_r.stall;
    assign o_irq = s_r.irq_out;

    property p_sel_guard;
        @(posedge i_clk) disable iff (!rst_n)
        (i_wr && i_addr == LACC_ADR_LOAD
         && i_wdata[19:LACC_SEL_LSB] != LACC_SEL_LOAD)
        |=> $stable(s_r.load_cfg);
    endproperty
    a_sel_guard: assert property (p_sel_guard) // RULE1
        else $error("load word taken with wrong selector");
    property p_filter_hold;
        @(posedge i_clk) disable iff (!rst_n)
        (s_r.stall_cfg[LACC_FILT_BIT] && !i_fullstep) |=> $stable(s_r.meas);
    endproperty
    a_filter_hold: assert property (p_filter_hold) // RULE9
        else $error("filtered measurement moved without full step");
    property p_irq_level;
        @(posedge i_clk) disable iff (!rst_n)
        o_irq == |(s_r.irq & s_r.mask);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("irq output mismatch");
    c_load_wr: cover property (@(posedge i_clk) disable iff (!rst_n)
        wr_load);
    c_stall: cover property (@(posedge i_clk) disable iff (!rst_n)
        $rose(o_stall_indicator_out));
endmodule

// file: test/lacc_host.sv
`timescale 1ns/1ns
module lacc_host (
    input wire logic i_clk,
    input wire logic [19:0] i_rdata,
    output logic [3:0] o_addr,
    output logic [19:0] o_wdata,
    output logic o_wr,
    output logic o_rd
);
    initial begin
        o_addr = 4'h0;
        o_wdata = 20'h0_0000;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    // words come whole from the bench with reserved bits zero
    task automatic wr(input logic [3:0] a, input logic [19:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
    endtask
    // data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [19:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        #1;
        d = i_rdata;
    endtask
endmodule

// file: test/test_load_adaptive_current_ctrl.sv
`timescale 1ns/1ns
module test_load_adaptive_current_ctrl;
    import lacc_pkg::*;
    logic clk, rst_n, wr, rd, mv, fs, stall, irq;
    logic [3:0] addr;
    logic [19:0] wdata, rdata, d;
    logic [9:0] meas, lm;
    logic [7:0] ca, cb, oa, ob;
    logic [4:0] fac;
    int bad_count = 0;
    int n_tests = 0;
    lacc_top #(.MEAS_W(10)) uut (.i_clk(clk), .i_rst_n(rst_n),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .i_meas_valid(mv), .i_meas(meas), .i_fullstep(fs),
        .i_coil_a(ca), .i_coil_b(cb), .o_rdata(rdata), .o_coil_a(oa),
        .o_coil_b(ob), .o_factor(fac), .o_load_measurement(lm),
        .o_stall_indicator_out(stall), .o_irq(irq));
    lacc_host host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr),
        .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [19:0] e,
        input logic [19:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [19:0] ld(input logic [3:0] lo,
        input logic [1:0] up, input logic [3:0] of, input logic [1:0] dn,
        input logic mn);
        return {LACC_SEL_LOAD, 1'b0, mn, dn, 1'b0, of, 1'b0, up, 1'b0, lo};
    endfunction
    function automatic logic [19:0] st(input logic fl,
        input logic [6:0] sg, input logic [4:0] cs);
        return {LACC_SEL_STALL, fl, 1'b0, sg, 3'h0, cs};
    endfunction
    // samples are two cycles apart, then the chain is let settle
    task automatic smp(input logic [9:0] m, input int n, input logic f);
        repeat (n) begin
            @(posedge clk);
            meas <= m;
            mv <= 1'b1;
            fs <= f;
            @(posedge clk);
            mv <= 1'b0;
            fs <= 1'b0;
        end
        repeat (3) @(posedge clk);
        #1;
    endtask
    // bounded wait; a miss ends the run at once
    task automatic wf(input logic [4:0] e);
        int i;
        for (i = 0; i < 8 && fac !== e; i++) begin
            @(posedge clk);
            #1;
        end
        chk("factor", {15'h0, e}, {15'h0, fac});
        if (fac !== e) summarize;
    endtask
    task automatic t_scale;
        chk("coil_a", 20'h0_0080, {12'h0, oa});
        host.wr(LACC_ADR_STALL, st(1'b0, 7'h00, 5'd20));
        smp(10'h000, 0, 1'b0);
        chk("coil_a", 20'h0_0054, {12'h0, oa});
        chk("coil_b", 20'h0_00a7, {12'h0, ob});
        chk("factor", 20'h0_0014, {15'h0, fac});
        host.rd(4'hf, d);
        chk("unmapped", 20'h0_0000, d);
        $display("test scale done");
    endtask
    task automatic t_bad;
        host.wr(LACC_ADR_MASK, 20'h0_0008);
        smp(10'h000, 0, 1'b0);
        chk("irq idle", 20'h0_0000, {19'h0, irq});
        host.wr(LACC_ADR_LOAD, 20'hC_0002);
        smp(10'h000, 0, 1'b0);
        chk("irq bad", 20'h0_0001, {19'h0, irq});
        host.rd(LACC_ADR_IRQ, d);
        chk("irq bit3", 20'h0_0008, d & 20'h0_0008);
        host.wr(LACC_ADR_IRQ, 20'h0_0008);
        smp(10'h000, 0, 1'b0);
        chk("irq clr", 20'h0_0000, {19'h0, irq});
        host.wr(LACC_ADR_MASK, 20'h0_0000);
        $display("test bad write done");
    endtask
    // fullstep count starts from reset: no step was sent before
    task automatic t_filter;
        host.wr(LACC_ADR_STALL, st(1'b1, 7'h00, 5'd31));
        smp(10'h12c, 1, 1'b0);
        chk("meas", 20'h0_0000, {10'h0, lm});
        smp(10'h12c, 3, 1'b1);
        chk("meas", 20'h0_0000, {10'h0, lm});
        smp(10'h12c, 1, 1'b1);
        chk("meas", 20'h0_012c, {10'h0, lm});
        $display("test filter done");
    endtask
    task automatic t_adapt;
        int k;
        host.wr(LACC_ADR_STALL, st(1'b0, 7'h00, 5'd31));
        host.wr(LACC_ADR_LOAD, ld(4'h2, 2'h3, 4'h0, 2'h3, 1'b0));
        smp(10'h000, 4, 1'b0);
        wf(5'd31);
        smp(10'h05f, 2, 1'b0);
        wf(5'd31);
        smp(10'h060, 3, 1'b0);
        wf(5'd28);
        smp(10'h060, 20, 1'b0);
        wf(5'd15);
        smp(10'h040, 1, 1'b0);
        wf(5'd15);
        smp(10'h03f, 1, 1'b0);
        wf(5'd23);
        smp(10'h03f, 1, 1'b0);
        wf(5'd31);
        for (k = 0; k < 4; k++) begin
            host.wr(LACC_ADR_LOAD, ld(4'h2, k[1:0], 4'h0, 2'h3, 1'b0));
            smp(10'h060, 16, 1'b0);
            smp(10'h000, 1, 1'b0);
            wf(5'd15 + (5'd1 << k));
        end
        $display("test adapt done");
    endtask
    task automatic t_slow;
        int k;
        int n;
        host.wr(LACC_ADR_LOAD, ld(4'h2, 2'h3, 4'h1, 2'h0, 1'b1));
        smp(10'h000, 4, 1'b0);
        smp(10'h07f, 5, 1'b0);
        wf(5'd31);
        smp(10'h080, 31, 1'b0);
        wf(5'd31);
        smp(10'h080, 1, 1'b0);
        wf(5'd30);
        for (k = 1; k < 3; k++) begin
            n = (k == 1) ? 8 : 2;
            host.wr(LACC_ADR_LOAD, ld(4'h2, 2'h3, 4'h1, k[1:0], 1'b1));
            smp(10'h000, 4, 1'b0);
            smp(10'h080, n - 1, 1'b0);
            wf(5'd31);
            smp(10'h080, 1, 1'b0);
            wf(5'd30);
        end
        host.wr(LACC_ADR_LOAD, ld(4'h2, 2'h3, 4'h1, 2'h3, 1'b1));
        smp(10'h080, 30, 1'b0);
        wf(5'd7);
        $display("test slow done");
    endtask
    task automatic sg(input logic [6:0] t, input logic [9:0] m,
        input logic e);
        host.wr(LACC_ADR_STALL, st(1'b0, t, 5'd31));
        smp(m, 1, 1'b0);
        chk("stall", {19'h0, e}, {19'h0, stall});
    endtask
    task automatic t_stall;
        sg(7'h40, 10'h040, 1'b1);
        sg(7'h40, 10'h041, 1'b0);
        sg(7'h3f, 10'h000, 1'b0);
        sg(7'h7f, 10'h001, 1'b1);
        $display("test stall done");
    endtask
    task automatic t_off;
        host.wr(LACC_ADR_STALL, st(1'b0, 7'h00, 5'd12));
        host.wr(LACC_ADR_LOAD, ld(4'h0, 2'h3, 4'h0, 2'h3, 1'b0));
        smp(10'h000, 4, 1'b0);
        wf(5'd12);
        chk("coil_a", 20'h0_0034, {12'h0, oa});
        $display("test off done");
    endtask
    initial begin
        rst_n = 1'b0;
        mv = 1'b0;
        fs = 1'b0;
        meas = 10'h000;
        ca = 8'h80;
        cb = 8'hff;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        // two sync edges, then factor and scaled coils need two more
        repeat (5) @(posedge clk);
        #1;
        t_scale;
        t_bad;
        t_filter;
        t_adapt;
        t_slow;
        t_stall;
        t_off;
        summarize;
    end
endmodule
